/* File: pfio_pkg.sv */
package pfio_pkg;
   // Byte addresses of the register words
   localparam logic [15:0] ADDR_DIR = 16'hfebe;
   localparam logic [15:0] ADDR_BCL = 16'hfed5;
   localparam logic [15:0] ADDR_SYS = 16'hff39;
   localparam logic [15:0] ADDR_FC1 = 16'hff45;
   localparam logic [15:0] ADDR_PIN = 16'hff5e;
   localparam logic [15:0] ADDR_LAT = 16'hff6e;
   localparam logic [15:0] ADDR_FC2 = 16'hffac;
   localparam logic [15:0] ADDR_MODE = 16'hff80;
   // Reset values and write masks
   localparam logic [7:0] RST_DIR_EXP = 8'h80;
   localparam logic [7:0] RST_DIR_SGL = 8'h00;
   localparam logic [7:0] RST_LAT = 8'h00;
   localparam logic [7:0] RST_BCL = 8'h3c;
   localparam logic [7:0] RST_SYS = 8'h01;
   localparam logic [7:0] RST_FC1 = 8'h0f;
   localparam logic [7:0] RST_FC2 = 8'h30;
   localparam logic [7:0] FC2_WMASK = 8'hf8;
   localparam logic [7:0] SYS_WMASK = 8'h3d;
   // Field positions
   localparam int FC1_CS5_SEL = 5;
   localparam int FC1_CS4_SEL = 4;
   localparam int FC2_CSA_EN = 4;
   localparam int FC2_AS_DIS = 3;
   localparam int SYS_LWR_DIS = 2;
   localparam int BCL_BRL_EN = 7;
   localparam int SBY_OUT_HOLD = 1;
   localparam int SBY_ENTER = 0;
   // Pin positions
   localparam int PIN_AS = 6;
   localparam int PIN_LWR = 3;
   localparam int PIN_CS5 = 1;
   localparam int PIN_CS4 = 0;
   // Operating mode, bus response codes and undefined read value
   localparam logic [2:0] MODE_SINGLE = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] UNDEF_READ = 32'h0000_0000;
endpackage : pfio_pkg

/* File: pfio_port.sv */
`timescale 1ns/1ps
// Operation
// - Direction register is eight-bit write-only; reads return an undefined value
// - Reset sets direction to 80 in modes 4-6, 00 in mode 7
// - Software standby keeps direction, latch and pin-state contents
// - Standby control bit chooses hold or high-impedance for bus outputs in standby
// - Output latch is eight-bit read/write, cleared to 00 at reset
// - Pin-state register is read-only; writes ignored; output data via latch
// - Pin-state read gives latch where direction is 1, pin where 0
// - First function control register is read/write, resets to 0f
// - Pin 1 drives chip select 5 when enabled, no bus release, direction 1
// - Pin 0 drives chip select 4 when enabled, no bus release, direction 1
// - First-register bits 3..0 enable address lines 23..20, reset to 1
// - Bits 7, 6 select chip selects for port G; second bit 5 enables group
// - Second function control register resets to 30
// - Second-register bit 4 enables chip selects 2 to 5 in modes 4-6
// - Second-register bit 3 at 0 makes pin 6 the address strobe
// - Second-register bits 7,6 writable reserved; bits 2..0 read zero
// - System control holds mode, edge, strobe disable, RAM bits; resets to 01
// - Low write strobe disable at 0 puts low write strobe on pin 3
// - Bus release enable at 0 leaves request, grant, drop pins as ports
module pfio_port (
   // Clock, reset and operating mode
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] op_mode,
   // Register bus
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   // Bus controller strobes routed to pins
   input wire logic address_strobe,
   input wire logic low_write_strobe,
   input wire logic chip_select_four,
   input wire logic chip_select_five,
   // Control fields for neighbouring blocks
   output logic [3:0] addr_line_enable,
   output logic select_chip_one_or_seven,
   output logic select_chip_three_or_six,
   output logic chip_select_group_b_enable,
   output logic chip_select_group_a_enable,
   output logic bus_release_enable,
   output logic [7:0] system_control_bits,
   output logic standby_active
);
   // Register layouts, low byte of each word
   // Direction: one bit per pin, 1 drives the pin
   // Output latch: drive value for all eight pins
   // Pin state: latch or pin level, chosen per direction bit
   // Bus control low: bit 7 bus release enable
   // System control: bits 5, 4 interrupt mode, bit 3 edge select
   // System control: bit 2 low strobe disable, bit 0 RAM enable
   // Function one: bits 7, 6 port G chip select choice
   // Function one: bits 5, 4 chip selects 5 and 4 on pins 1, 0
   // Function one: bits 3..0 address lines 23..20
   // Function two: bits 7, 6 reserved but writable
   // Function two: bit 5 group b enable, bit 4 group a enable
   // Function two: bit 3 address strobe disable, bits 2..0 zero
   // Standby control: bit 0 enter standby, bit 1 hold bus outputs

   // Pin map in modes 4 to 6
   // Pin 6 carries the address strobe unless disabled
   // Pin 3 carries the low write strobe unless disabled
   // Pin 1 carries chip select 5 when selected and enabled
   // Pin 0 carries chip select 4 when selected and enabled
   // Every other pin, and all pins in mode 7, is a plain port
   // A changed chip select enable only moves pin 1 or 0 once its direction bit allows it
   // Bus release enable returns both chip select pins to plain port use

   // All state lives in one packed record, registered as a whole
   typedef struct packed {
      // Software registers
      logic [7:0] dir;
      logic [7:0] lat;
      logic [7:0] bcl;
      logic [7:0] sys;
      logic [7:0] fc1;
      logic [7:0] fc2;
      // Standby control and snapshots
      logic [1:0] sby;
      logic [7:0] pin_hold;
      logic [7:0] drv_hold;
      logic [7:0] oe_hold;
      // Reset sequencing and write channel
      logic init;
      logic aw_got;
      logic w_got;
      logic [15:0] aw_adr;
      logic [31:0] w_dat;
      logic [3:0] w_stb;
      // Response and read channel
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } pfio_state_t;

   pfio_state_t st_ff;
   pfio_state_t nxt_st;
   logic expanded;
   logic [7:0] func_drv;
   logic [7:0] func_sel;
   logic [7:0] live_out;
   logic [7:0] live_oe;
   logic [7:0] pin_view;
   logic do_wr;
   logic [31:0] rd_word;
   logic rd_ok;

   // Byte lane merge of an 8-bit register in the low lane
   function automatic logic [7:0] pfio_merge(input logic [7:0] old_v, input logic [31:0] d,
                                             input logic [3:0] stb, input logic [7:0] wmask);
      pfio_merge = stb[0] ? ((old_v & ~wmask) | (d[7:0] & wmask)) : old_v;
   endfunction : pfio_merge

   // Word decode of a byte address
   function automatic logic pfio_hit(input logic [15:0] a, input logic [15:0] reg_a);
      pfio_hit = (a[15:2] == reg_a[15:2]);
   endfunction : pfio_hit

   assign expanded = (op_mode != pfio_pkg::MODE_SINGLE);

   // Bus function overrides per pin
   always_comb begin
      func_drv = 8'h00;
      func_sel = 8'h00;
      // Address strobe on pin 6
      if (expanded && !st_ff.fc2[pfio_pkg::FC2_AS_DIS]) begin
         func_sel[pfio_pkg::PIN_AS] = 1'b1;
         func_drv[pfio_pkg::PIN_AS] = address_strobe;
      end
      // Low write strobe on pin 3
      if (expanded && !st_ff.sys[pfio_pkg::SYS_LWR_DIS]) begin
         func_sel[pfio_pkg::PIN_LWR] = 1'b1;
         func_drv[pfio_pkg::PIN_LWR] = low_write_strobe;
      end
      // Chip select 5 on pin 1, only with release off and group a on
      if (expanded && st_ff.fc1[pfio_pkg::FC1_CS5_SEL] && !st_ff.bcl[pfio_pkg::BCL_BRL_EN]
          && st_ff.fc2[pfio_pkg::FC2_CSA_EN] && st_ff.dir[pfio_pkg::PIN_CS5]) begin
         func_sel[pfio_pkg::PIN_CS5] = 1'b1;
         func_drv[pfio_pkg::PIN_CS5] = chip_select_five;
      end
      // Chip select 4 on pin 0, same conditions
      if (expanded && st_ff.fc1[pfio_pkg::FC1_CS4_SEL] && !st_ff.bcl[pfio_pkg::BCL_BRL_EN]
          && st_ff.fc2[pfio_pkg::FC2_CSA_EN] && st_ff.dir[pfio_pkg::PIN_CS4]) begin
         func_sel[pfio_pkg::PIN_CS4] = 1'b1;
         func_drv[pfio_pkg::PIN_CS4] = chip_select_four;
      end
   end

   // Pin drive: bus function wins, else latch under direction
   always_comb begin
      live_out = (func_sel & func_drv) | (~func_sel & st_ff.lat);
      live_oe = func_sel | st_ff.dir;
   end

   // Standby: bus outputs hold or float, port pins keep their state
   // Drive values come from the snapshot taken on the entering edge
   // With hold off, only pins that carried a bus function are released
   // Port pins keep driving their latched level either way
   // Leaving standby returns every pin to its live value at once
   always_comb begin
      pin_out = st_ff.sby[pfio_pkg::SBY_ENTER] ? st_ff.drv_hold : live_out;
      pin_oe = live_oe;
      if (st_ff.sby[pfio_pkg::SBY_ENTER]) begin
         pin_oe = st_ff.sby[pfio_pkg::SBY_OUT_HOLD] ? st_ff.oe_hold : (st_ff.oe_hold & ~func_sel);
      end
   end

   // Pin-state view
   assign pin_view = st_ff.sby[pfio_pkg::SBY_ENTER] ? st_ff.pin_hold
                     : ((st_ff.dir & st_ff.lat) | (~st_ff.dir & pin_in));

   // Write fires once both halves are held and no response is pending
   // Register update and response share one edge
   assign do_wr = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;

   // Read data selection by word address; unmapped words answer with an error
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      unique case (1'b1)
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_DIR): begin
            rd_word = pfio_pkg::UNDEF_READ;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_LAT): begin
            rd_word[7:0] = st_ff.lat;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_PIN): begin
            rd_word[7:0] = pin_view;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_BCL): begin
            rd_word[7:0] = st_ff.bcl;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_SYS): begin
            rd_word[7:0] = st_ff.sys;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_FC1): begin
            rd_word[7:0] = st_ff.fc1;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_FC2): begin
            rd_word[7:0] = st_ff.fc2;
         end
         pfio_hit(s_axi_araddr[15:0], pfio_pkg::ADDR_MODE): begin
            rd_word[1:0] = st_ff.sby;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   // Register bus timing
   // Write address and data are taken in either order, each while its ready is high
   // The edge after both are held updates the register and raises the response
   // The response stands until the master's ready is seen with it
   // One write is held at a time; address and data readies return high on the update edge
   // A read is taken while no read response is pending
   // Read data and status are captured on the taking edge and stand until accepted
   // Reads of the pin state reflect the level at the taking edge, the same edge that raises the answer
   // Only the low byte lane carries register data; upper lanes read zero
   // The first edge after reset loads the mode-dependent direction value
   // Standby snapshots follow the live pins until standby is entered

   // Next state
   always_comb begin
      nxt_st = st_ff;
      if (!st_ff.init) begin
         nxt_st.init = 1'b1;
         nxt_st.dir = expanded ? pfio_pkg::RST_DIR_EXP : pfio_pkg::RST_DIR_SGL;
      end
      if (!st_ff.sby[pfio_pkg::SBY_ENTER]) begin
         nxt_st.pin_hold = pin_view;
         nxt_st.drv_hold = live_out;
         nxt_st.oe_hold = live_oe;
      end
      // Write address and data taken in either order
      if (s_axi_awvalid && !st_ff.aw_got) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.aw_adr = s_axi_awaddr[15:0];
      end
      if (s_axi_wvalid && !st_ff.w_got) begin
         nxt_st.w_got = 1'b1;
         nxt_st.w_dat = s_axi_wdata;
         nxt_st.w_stb = s_axi_wstrb;
      end
      if (st_ff.bvalid && s_axi_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (do_wr) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = pfio_pkg::RESP_OKAY;
         unique case (1'b1)
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_DIR): begin
               // Direction takes every bit
               nxt_st.dir = pfio_merge(st_ff.dir, st_ff.w_dat, st_ff.w_stb, 8'hff);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_LAT): begin
               // Latch takes every bit
               nxt_st.lat = pfio_merge(st_ff.lat, st_ff.w_dat, st_ff.w_stb, 8'hff);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_BCL): begin
               // Bus control low takes every bit
               nxt_st.bcl = pfio_merge(st_ff.bcl, st_ff.w_dat, st_ff.w_stb, 8'hff);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_SYS): begin
               // Bits outside the mask keep their value
               nxt_st.sys = pfio_merge(st_ff.sys, st_ff.w_dat, st_ff.w_stb,
                                       pfio_pkg::SYS_WMASK);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_FC1): begin
               // Every bit writable
               nxt_st.fc1 = pfio_merge(st_ff.fc1, st_ff.w_dat, st_ff.w_stb, 8'hff);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_FC2): begin
               // Bits 2..0 stay zero
               nxt_st.fc2 = pfio_merge(st_ff.fc2, st_ff.w_dat, st_ff.w_stb,
                                       pfio_pkg::FC2_WMASK);
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_MODE): begin
               // Standby control, low lane only
               nxt_st.sby = st_ff.w_stb[0] ? st_ff.w_dat[1:0] : st_ff.sby;
            end
            pfio_hit(st_ff.aw_adr, pfio_pkg::ADDR_PIN): begin
               // Pin state drops the data but still answers okay
            end
            default: begin
               // Unmapped word
               nxt_st.bresp = pfio_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Read channel
      if (st_ff.rvalid && s_axi_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = rd_ok ? pfio_pkg::RESP_OKAY : pfio_pkg::RESP_SLVERR;
         nxt_st.rdata = rd_word;
      end
   end

   // State register; reset loads constants, mode-dependent direction one cycle later
   always_ff @(posedge clk) begin
      if (rst) begin
         // Clear everything, then load the documented reset values
         // Direction stays zero here and follows the mode one edge later
         st_ff <= '0;
         st_ff.lat <= pfio_pkg::RST_LAT;
         st_ff.bcl <= pfio_pkg::RST_BCL;
         st_ff.sys <= pfio_pkg::RST_SYS;
         st_ff.fc1 <= pfio_pkg::RST_FC1;
         st_ff.fc2 <= pfio_pkg::RST_FC2;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Handshake and control outputs
   assign s_axi_awready = !st_ff.aw_got;
   assign s_axi_wready = !st_ff.w_got;
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_arready = !st_ff.rvalid;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rresp = st_ff.rresp;
   assign s_axi_rdata = st_ff.rdata;
   // Function control fields, passed straight out except group a, which is gated by mode
   assign addr_line_enable = st_ff.fc1[3:0];
   assign select_chip_one_or_seven = st_ff.fc1[7];
   assign select_chip_three_or_six = st_ff.fc1[6];
   assign chip_select_group_b_enable = st_ff.fc2[5];
   assign chip_select_group_a_enable = st_ff.fc2[pfio_pkg::FC2_CSA_EN] && expanded;
   // Bus, system and standby fields
   assign bus_release_enable = st_ff.bcl[pfio_pkg::BCL_BRL_EN];
   assign system_control_bits = st_ff.sys;
   assign standby_active = st_ff.sby[pfio_pkg::SBY_ENTER];
endmodule : pfio_port

/* File: pfio_ext_model.sv */
`timescale 1ns/1ps
// Far side of the port pins: lines not driven by the port carry the outside level
module pfio_ext_model (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_in
);
   // Each wire resolves to the port drive where enabled, else to the outside level
   assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pfio_ext_model

/* File: pfio_port_asserts.sv */
`timescale 1ns/1ps
// Ties reset values and pin routing to mode and reset
module pfio_port_asserts (
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] op_mode,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [3:0] addr_line_enable,
   input wire logic chip_select_group_b_enable,
   input wire logic chip_select_group_a_enable,
   input wire logic bus_release_enable,
   input wire logic [7:0] system_control_bits,
   input wire logic standby_active
);
   wire single = op_mode == pfio_pkg::MODE_SINGLE;
   // All checks sample on the rising edge outside reset
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   addr_rst_a: assert property ($fell(rst) |-> addr_line_enable == 4'hf)
      else $error("address enables wrong after reset");
   grp_rst_a: assert property ($fell(rst) |-> chip_select_group_b_enable)
      else $error("chip select group b off after reset");
   sys_rst_a: assert property ($fell(rst) |-> system_control_bits == 8'h01)
      else $error("system control wrong after reset");
   brl_rst_a: assert property ($fell(rst) |-> !bus_release_enable)
      else $error("bus release on after reset");
   grpa_mode_a: assert property (single |-> !chip_select_group_a_enable)
      else $error("chip select group a on in single chip mode");
   dir_exp_a: assert property ($fell(rst) && !single |=> pin_oe[7])
      else $error("pin seven not output after expanded reset");
   dir_sgl_a: assert property ($fell(rst) && single |=> pin_oe == 8'h00)
      else $error("pins driven after single chip reset");
   stby_hold_a: assert property (standby_active && $past(standby_active) &&
      single |-> $stable(pin_out) && $stable(pin_oe)) else $error("pins moved in standby");
endmodule : pfio_port_asserts

/* File: port_f_io_and_bus_pin_control_tb.sv */
`timescale 1ns/1ps
module port_f_io_and_bus_pin_control_tb;
   logic clk, rst, awv, wv, arv, bready, rready, awready, wready, arready, bvalid, rvalid;
   logic as_in, lwr_in, cs4_in, cs5_in, sel17, sel36, grp_b, grp_a, brl, stby;
   logic [2:0] op_mode;
   logic [3:0] a_en;
   logic [31:0] awaddr, wdata, araddr, rdata, data;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] pin_in, pin_out, pin_oe, ext_level, sys_bits;
   int n_errors = 0;
   int n_tests = 0;
   // Rows: write flag, address, write data, expected read
   logic [32:0] rows [10] = '{
      {1'h0, pfio_pkg::ADDR_LAT, 16'h0000}, {1'h0, pfio_pkg::ADDR_FC1, 16'h000f},
      {1'h0, pfio_pkg::ADDR_FC2, 16'h0030}, {1'h0, pfio_pkg::ADDR_SYS, 16'h0001},
      {1'h0, pfio_pkg::ADDR_BCL, 16'h003c}, {1'h0, pfio_pkg::ADDR_DIR, 16'h0000},
      {1'h1, pfio_pkg::ADDR_LAT, 16'ha5a5}, {1'h1, pfio_pkg::ADDR_FC1, 16'h3a3a},
      {1'h1, pfio_pkg::ADDR_FC2, 16'hfff8}, {1'h1, pfio_pkg::ADDR_SYS, 16'hff3d}};
   pfio_port dut_u (.clk(clk), .rst(rst), .op_mode(op_mode),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .address_strobe(as_in),
      .low_write_strobe(lwr_in), .chip_select_four(cs4_in), .chip_select_five(cs5_in),
      .addr_line_enable(a_en), .select_chip_one_or_seven(sel17),
      .select_chip_three_or_six(sel36), .chip_select_group_b_enable(grp_b),
      .chip_select_group_a_enable(grp_a), .bus_release_enable(brl),
      .system_control_bits(sys_bits), .standby_active(stby));
   pfio_ext_model ext_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
      .pin_in(pin_in));
   // Free-running 25 MHz clock
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // One register access; channels released as each is taken
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
      output logic [31:0] q, output logic [1:0] r);
      logic ta, tw, tr, done;
      @(posedge clk);
      awaddr <= {16'h0, a};
      wdata <= {24'h0, d};
      araddr <= {16'h0, a};
      awv <= w;
      wv <= w;
      bready <= w;
      arv <= !w;
      rready <= !w;
      do begin
         @(negedge clk);
         ta = awv & awready;
         tw = wv & wready;
         tr = arv & arready;
         done = w ? bvalid : rvalid;
         q = rdata;
         r = w ? bresp : rresp;
         @(posedge clk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
         if (tr) arv <= 1'h0;
      end while (!done);
      bready <= 1'h0;
      rready <= 1'h0;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic do_reset(input logic [2:0] m);
      @(posedge clk);
      rst <= 1'h1;
      op_mode <= m;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
   endtask : do_reset
   task automatic give_verdict();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict
   // Cuts a hang short well past the expected run time
   initial begin
      #200000;
      n_errors++;
      give_verdict();
   end
   // Main sequence: table first, then strobe routing, modes and standby
   initial begin
      {rst, awv, wv, arv, bready, rready, as_in, lwr_in, cs4_in, cs5_in} = 10'h200;
      {op_mode, awaddr, wdata, araddr, ext_level} = '0;
      do_reset(3'h4);
      foreach (rows[i]) begin
         if (rows[i][32]) bus(1'h1, rows[i][31:16], rows[i][15:8], data, resp);
         bus(1'h0, rows[i][31:16], 8'h00, data, resp);
         chk(data, {24'h0, rows[i][7:0]});
      end
      bus(1'h1, pfio_pkg::ADDR_FC2, 8'h30, data, resp);
      bus(1'h1, pfio_pkg::ADDR_SYS, 8'h01, data, resp);
      chk({24'h0, sys_bits}, 32'h01);
      bus(1'h1, pfio_pkg::ADDR_DIR, 8'h03, data, resp);
      {as_in, lwr_in, cs4_in, cs5_in} <= 4'hd;
      @(negedge clk);
      chk({24'h0, pin_out & 8'h4b}, 32'h4a);
      chk({24'h0, pin_oe & 8'h4b}, 32'h4b);
      @(posedge clk);
      {as_in, lwr_in, cs4_in, cs5_in} <= 4'h2;
      @(negedge clk);
      chk({24'h0, pin_out & 8'h4b}, 32'h01);
      bus(1'h1, pfio_pkg::ADDR_BCL, 8'hbc, data, resp);
      {cs4_in, cs5_in} <= 2'h1;
      @(negedge clk);
      chk({30'h0, pin_out[1:0]}, 32'h1);
      chk({31'h0, brl}, 32'h1);
      bus(1'h0, 16'hff00, 8'h00, data, resp);
      chk({30'h0, resp}, {30'h0, pfio_pkg::RESP_SLVERR});
      do_reset(pfio_pkg::MODE_SINGLE);
      @(negedge clk);
      chk({23'h0, grp_a, pin_oe}, 32'h0);
      bus(1'h1, pfio_pkg::ADDR_DIR, 8'h0f, data, resp);
      bus(1'h1, pfio_pkg::ADDR_LAT, 8'h3c, data, resp);
      ext_level <= 8'ha5;
      bus(1'h1, pfio_pkg::ADDR_PIN, 8'h00, data, resp);
      chk({30'h0, resp}, {30'h0, pfio_pkg::RESP_OKAY});
      bus(1'h0, pfio_pkg::ADDR_PIN, 8'h00, data, resp);
      chk(data, 32'hac);
      @(negedge clk);
      chk({16'h0, pin_oe, pin_out & 8'h0f}, 32'h0f0c);
      bus(1'h1, pfio_pkg::ADDR_MODE, 8'h01, data, resp);
      ext_level <= 8'h5a;
      bus(1'h0, pfio_pkg::ADDR_PIN, 8'h00, data, resp);
      chk(data, 32'hac);
      bus(1'h0, pfio_pkg::ADDR_LAT, 8'h00, data, resp);
      chk({data[30:0], stby}, 32'h79);
      chk({24'h0, pin_oe}, 32'h0f);
      bus(1'h1, pfio_pkg::ADDR_FC1, 8'hc5, data, resp);
      chk({26'h0, sel17, sel36, a_en}, 32'h35);
      give_verdict();
   end
endmodule : port_f_io_and_bus_pin_control_tb
bind pfio_port pfio_port_asserts chk_u (.clk(clk), .rst(rst), .op_mode(op_mode),
   .pin_out(pin_out), .pin_oe(pin_oe), .addr_line_enable(addr_line_enable),
   .chip_select_group_b_enable(chip_select_group_b_enable),
   .chip_select_group_a_enable(chip_select_group_a_enable),
   .bus_release_enable(bus_release_enable), .system_control_bits(system_control_bits),
   .standby_active(standby_active));
